// ===== hdl/mmd_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmd_cfg.svh"
module mmd_decode
  import mmd_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  // strap and lock inputs
  input  wire logic [2:0]  lane_strap_i,
  input  wire logic        trusted_lock_bit_i,
  // configuration register port
  input  wire logic        cfg_wr_i,
  input  wire logic        cfg_rd_i,
  input  wire logic [3:0]  cfg_idx_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic [31:0]      cfg_rdata_o,
  output logic             cfg_ack_o,
  // inbound address decode
  input  wire logic        dec_valid_i,
  input  wire logic        dec_is64_i,
  input  wire logic [63:0] dec_addr_i,
  output logic             dec_done_o,
  output logic             main_mem_o,
  output logic             prot_hit_o,
  output logic             noncoh_o,
  // configuration access check
  input  wire logic        acc_valid_i,
  input  wire logic [2:0]  acc_src_i,
  input  wire logic [4:0]  acc_dev_i,
  input  wire logic [2:0]  acc_func_i,
  input  wire logic        acc_secondary_i,
  output logic             acc_done_o,
  output logic             acc_abort_o
);

  logic [2:0]  lane_strap;         // captured strap code
  logic [11:0] protected_window_base;
  logic [2:0]  protected_window_size;
  logic        protected_window_enable;
  logic        pw_written;         // write-once consumed
  logic [5:0]  low_memory_top_field;
  logic [37:0] high_memory_top_field;
  logic [37:0] noncoherent_base_field;
  logic [37:0] noncoherent_limit_field;
  logic [31:0] hide1;              // first hide register
  logic [31:0] hide2;              // second hide register
  logic [32:0] pw_lo;              // window start, bytes
  logic [32:0] pw_hi;              // window end, exclusive
  logic [32:0] addr33;             // low address, widened
  logic        hide_hit;           // target hidden now

  // window size in bytes; zero for reserved codes
  function automatic logic [32:0] pw_bytes(input logic [2:0] code);
    pw_bytes = 33'h0;
    if (code <= 3'h4) begin
      pw_bytes = `MMD_PW_MIN_BYTES << code;
    end
  endfunction

  // is this device/function hidden from a host access
  function automatic logic hidden(input logic [31:0] h1,
                                  input logic [31:0] h2,
                                  input logic [4:0]  dev,
                                  input logic [2:0]  fn);
    hidden = 1'b0;
    case (dev)
      5'd0, 5'd3, 5'd4, 5'd5, 5'd6: begin
        hidden = h1[dev];
      end
      5'd8: begin
        case (fn)
          3'd0:    hidden = h2[3];
          3'd1:    hidden = h2[4];
          3'd2:    hidden = h2[5];
          3'd3:    hidden = h1[12];
          default: hidden = 1'b0;
        endcase
      end
      5'd16: begin
        if (fn == 3'd0) begin
          hidden = h1[26];
        end else if (fn == 3'd1) begin
          hidden = h1[27];
        end
      end
      default: hidden = 1'b0;
    endcase
  endfunction

  // strap is sampled while reset is held, then frozen
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      lane_strap <= lane_strap_i;
    end
  end

  // protected window control, write once after reset
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      protected_window_base   <= `MMD_PW_BASE_RST;
      protected_window_size   <= `MMD_PW_SIZE_RST;
      protected_window_enable <= `MMD_PW_EN_RST;
      pw_written              <= 1'b0;
    end else if (cfg_wr_i && cfg_idx_i == `MMD_IDX_PWIN && !pw_written) begin
      // reserved bits 19:4 simply not stored
      protected_window_base   <= cfg_wdata_i[31:20];
      protected_window_size   <= cfg_wdata_i[3:1];
      protected_window_enable <= cfg_wdata_i[0];
      pw_written              <= 1'b1;
    end
  end

  // memory top limits; software is trusted to set high once
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      low_memory_top_field  <= 6'h00;
      high_memory_top_field <= 38'h0;
    end else if (cfg_wr_i) begin
      case (cfg_idx_i)
        `MMD_IDX_LOTOP: begin
          low_memory_top_field <= cfg_wdata_i[31:26];
        end
        `MMD_IDX_HITOP_L: begin
          high_memory_top_field[5:0] <= cfg_wdata_i[31:26];
        end
        `MMD_IDX_HITOP_H: begin
          high_memory_top_field[37:6] <= cfg_wdata_i;
        end
        default: begin
        end
      endcase
    end
  end

  // non-coherent range, empty (base above limit) at reset
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      noncoherent_base_field  <= `MMD_NC_BASE_RST;
      noncoherent_limit_field <= `MMD_NC_LIM_RST;
    end else if (cfg_wr_i) begin
      case (cfg_idx_i)
        `MMD_IDX_NCBASE_L: noncoherent_base_field[5:0]   <= cfg_wdata_i[31:26];
        `MMD_IDX_NCBASE_H: noncoherent_base_field[37:6]  <= cfg_wdata_i;
        `MMD_IDX_NCLIM_L:  noncoherent_limit_field[5:0]  <= cfg_wdata_i[31:26];
        `MMD_IDX_NCLIM_H:  noncoherent_limit_field[37:6] <= cfg_wdata_i;
        default: begin
        end
      endcase
    end
  end

  // hide registers; device sixteen bits freeze under lock
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      hide1 <= `MMD_HIDE_RST;
      hide2 <= `MMD_HIDE_RST;
    end else if (cfg_wr_i && cfg_idx_i == `MMD_IDX_HIDE1) begin
      if (trusted_lock_bit_i) begin
        // keep locked bits, update the rest
        hide1 <= (hide1 & `MMD_HIDE1_LOCKED) |
                 (cfg_wdata_i & `MMD_HIDE1_WMASK & ~`MMD_HIDE1_LOCKED);
      end else begin
        hide1 <= cfg_wdata_i & `MMD_HIDE1_WMASK;
      end
    end else if (cfg_wr_i && cfg_idx_i == `MMD_IDX_HIDE2) begin
      hide2 <= cfg_wdata_i & `MMD_HIDE2_WMASK;
    end
  end

  // register read-back, one cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cfg_rdata_o <= 32'h0000_0000;
      cfg_ack_o   <= 1'b0;
    end else begin
      cfg_ack_o   <= cfg_rd_i | cfg_wr_i;
      cfg_rdata_o <= 32'h0000_0000; // unmapped reads zero
      if (cfg_rd_i) begin
        case (cfg_idx_i)
          `MMD_IDX_STRAP:    cfg_rdata_o <= `MMD_STRAP_FIXED | {29'h0, lane_strap};
          `MMD_IDX_PWIN:     cfg_rdata_o <= {protected_window_base, 16'h0000,
                                             protected_window_size,
                                             protected_window_enable};
          `MMD_IDX_LOTOP:    cfg_rdata_o <= {low_memory_top_field, 26'h0};
          `MMD_IDX_HITOP_L:  cfg_rdata_o <= {high_memory_top_field[5:0], 26'h0};
          `MMD_IDX_HITOP_H:  cfg_rdata_o <= high_memory_top_field[37:6];
          `MMD_IDX_NCBASE_L: cfg_rdata_o <= {noncoherent_base_field[5:0], 26'h0};
          `MMD_IDX_NCBASE_H: cfg_rdata_o <= noncoherent_base_field[37:6];
          `MMD_IDX_NCLIM_L:  cfg_rdata_o <= {noncoherent_limit_field[5:0], 26'h0};
          `MMD_IDX_NCLIM_H:  cfg_rdata_o <= noncoherent_limit_field[37:6];
          `MMD_IDX_HIDE1:    cfg_rdata_o <= hide1;
          `MMD_IDX_HIDE2:    cfg_rdata_o <= hide2;
          default:           cfg_rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // protected window bounds, 33 bits so the end never wraps
  always_comb begin
    pw_lo  = {1'b0, protected_window_base, 20'h00000};
    pw_hi  = pw_lo + pw_bytes(protected_window_size);
    addr33 = {1'b0, dec_addr_i[31:0]};
  end

  // address classification, registered one cycle
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      dec_done_o <= 1'b0;
      main_mem_o <= 1'b0;
      prot_hit_o <= 1'b0;
      noncoh_o   <= 1'b0;
    end else begin
      dec_done_o <= dec_valid_i;
      main_mem_o <= 1'b0;
      prot_hit_o <= 1'b0;
      noncoh_o   <= 1'b0;
      if (dec_valid_i) begin
        if (!dec_is64_i) begin
          // low region always starts at zero
          main_mem_o <= dec_addr_i[31:26] <= low_memory_top_field;
        end else begin
          main_mem_o <= (dec_addr_i[63:32] != 32'h0) &&
                        (dec_addr_i[63:26] <= high_memory_top_field);
        end
        // reserved size codes give an empty window
        prot_hit_o <= protected_window_enable && (dec_addr_i[63:32] == 32'h0) &&
                      (addr33 >= pw_lo) && (addr33 < pw_hi);
        noncoh_o <= (dec_addr_i[63:26] >= noncoherent_base_field) &&
                    (dec_addr_i[63:26] <= noncoherent_limit_field);
      end
    end
  end

  // only host primary-side config accesses can be hidden
  always_comb begin
    hide_hit = (acc_src_i == MMD_SRC_HOST) && !acc_secondary_i &&
               hidden(hide1, hide2, acc_dev_i, acc_func_i);
  end

  // config access verdict, one cycle after request
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      acc_done_o  <= 1'b0;
      acc_abort_o <= 1'b0;
    end else begin
      acc_done_o  <= acc_valid_i;
      acc_abort_o <= acc_valid_i && hide_hit;
    end
  end

  default clocking dc @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  strap_read_a: assert property (
    cfg_rd_i && cfg_idx_i == `MMD_IDX_STRAP |=> cfg_rdata_o[2:0] == lane_strap
      && cfg_rdata_o[31:5] == 27'h0)
    else $error("strap read mismatch");

  pw_reset_a: assert property (
    !$past(nrst_i) |-> protected_window_base == 12'hFE0
      && protected_window_size == 3'h4 && protected_window_enable)
    else $error("window reset values wrong");

  pw_once_a: assert property (
    pw_written && cfg_wr_i && cfg_idx_i == `MMD_IDX_PWIN |=> $stable(protected_window_base)
      && $stable(protected_window_size) && $stable(protected_window_enable))
    else $error("write-once field changed");

  pw_disable_a: assert property (
    dec_valid_i && !protected_window_enable |=> !prot_hit_o)
    else $error("disabled window hit");

  pw_min_a: assert property (
    dec_valid_i && protected_window_enable && protected_window_size == 3'h0
      && dec_addr_i[63:32] == 32'h0
      && dec_addr_i[31:19] == {protected_window_base, 1'b1} |=> !prot_hit_o)
    else $error("512 KB window too large");

  low_mem_a: assert property (
    dec_valid_i && !dec_is64_i |=> main_mem_o ==
      ($past(dec_addr_i[31:26]) <= $past(low_memory_top_field)))
    else $error("low memory decode wrong");

  high_mem_a: assert property (
    dec_valid_i && dec_is64_i && dec_addr_i[63:32] == 32'h0 |=> !main_mem_o)
    else $error("below 4 GB hit high memory");

  // second edge after release is the earliest a request can land
  nc_empty_a: assert property (
    !$past(nrst_i, 2) && !$past(cfg_wr_i) && dec_valid_i |=> !noncoh_o)
    else $error("non-coherent hit after reset");

  hide_abort_a: assert property (
    acc_valid_i && acc_src_i == MMD_SRC_HOST && !acc_secondary_i
      && acc_dev_i == 5'd0 && hide1[0] |=> acc_done_o && acc_abort_o)
    else $error("hidden access not aborted");

  jtag_pass_a: assert property (
    acc_valid_i && acc_src_i == MMD_SRC_JTAG |=> acc_done_o && !acc_abort_o)
    else $error("test port access aborted");

  hide_lock_a: assert property (
    trusted_lock_bit_i && cfg_wr_i && cfg_idx_i == `MMD_IDX_HIDE1 |=> $stable(hide1[27:26]))
    else $error("locked hide bits changed");

endmodule
`default_nettype wire

// ===== hdl/mmd_cfg.svh
`ifndef MMD_CFG_SVH
`define MMD_CFG_SVH
// register indices in configuration space
`define MMD_IDX_STRAP    4'h0
`define MMD_IDX_PWIN     4'h1
`define MMD_IDX_LOTOP    4'h2
`define MMD_IDX_HITOP_L  4'h3
`define MMD_IDX_HITOP_H  4'h4
`define MMD_IDX_NCBASE_L 4'h5
`define MMD_IDX_NCBASE_H 4'h6
`define MMD_IDX_NCLIM_L  4'h7
`define MMD_IDX_NCLIM_H  4'h8
`define MMD_IDX_HIDE1    4'h9
`define MMD_IDX_HIDE2    4'hA
// field positions
`define MMD_PW_BASE_LSB  20
`define MMD_PW_SIZE_LSB  1
`define MMD_GRAN_LSB     26
// lane split strap codes
`define MMD_LANE_X16     3'h7
`define MMD_LANE_X8X8    3'h6
`define MMD_LANE_X4      3'h5
// reset values
`define MMD_STRAP_FIXED  32'h0000_0018
`define MMD_PW_BASE_RST  12'hFE0
`define MMD_PW_SIZE_RST  3'h4
`define MMD_PW_EN_RST    1'b1
`define MMD_NC_BASE_RST  38'h3F_FFFF_FFFF
`define MMD_NC_LIM_RST   38'h00_0000_0000
`define MMD_HIDE_RST     32'h0000_0000
// writable and lock-protected bit masks
`define MMD_HIDE1_WMASK  32'h0C00_1079
`define MMD_HIDE2_WMASK  32'h0000_0038
`define MMD_HIDE1_LOCKED 32'h0C00_0000
// smallest protected window in bytes
`define MMD_PW_MIN_BYTES 33'h0_0008_0000
`endif

// ===== hdl/mmd_pkg.sv
package mmd_pkg;
  // originator of a configuration access, one-hot
  typedef enum logic [2:0] {
    MMD_SRC_HOST  = 3'b001,
    MMD_SRC_JTAG  = 3'b010,
    MMD_SRC_SMBUS = 3'b100
  } mmd_src_t;
endpackage

// ===== verif/mmd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host interconnect model: issues decode and config access requests
module mmd_host_model
  import mmd_pkg::*;
(
  // clock
  input  wire logic   core_clk_i,
  // decode request
  output logic        dec_valid_o,
  output logic        dec_is64_o,
  output logic [63:0] dec_addr_o,
  // config access request
  output logic        acc_valid_o,
  output logic [2:0]  acc_src_o,
  output logic [4:0]  acc_dev_o,
  output logic [2:0]  acc_func_o,
  output logic        acc_sec_o
);
  // idle at time zero
  initial begin
    {dec_valid_o, dec_is64_o, dec_addr_o} = '0;
    {acc_valid_o, acc_src_o, acc_dev_o, acc_func_o, acc_sec_o} = '0;
  end
  // one decode request, taken at a single edge
  task automatic dec(input logic [63:0] a, input logic w);
    @(negedge core_clk_i);
    dec_valid_o = 1'b1;
    dec_is64_o  = w;
    dec_addr_o  = a;
    @(negedge core_clk_i);
    dec_valid_o = 1'b0;
    // released lines never keep the last value
    dec_addr_o  = ~a;
    dec_is64_o  = ~w;
  endtask
  // one config access request
  task automatic acc(input logic [2:0] s, input logic [4:0] d, input logic [2:0] f,
                     input logic sec);
    @(negedge core_clk_i);
    acc_valid_o = 1'b1;
    acc_src_o   = s;
    acc_dev_o   = d;
    acc_func_o  = f;
    acc_sec_o   = sec;
    @(negedge core_clk_i);
    acc_valid_o = 1'b0;
    {acc_src_o, acc_dev_o, acc_func_o, acc_sec_o} = ~{s, d, f, sec};
  endtask
endmodule
`default_nettype wire

// ===== verif/memory_map_decode_and_config_hide_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmd_cfg.svh"
module memory_map_decode_and_config_hide_tb
  import mmd_pkg::*;
;
  logic        core_clk_i = 1'b0;
  logic        nrst_i, cfg_wr_i, cfg_rd_i, trusted_lock_bit_i;
  logic [2:0]  lane_strap_i;
  logic [3:0]  cfg_idx_i;
  logic [31:0] cfg_wdata_i, cfg_rdata_o;
  logic        cfg_ack_o, dec_done_o, main_mem_o, prot_hit_o, noncoh_o, acc_done_o, acc_abort_o;
  logic        dec_valid, dec_is64, acc_valid, acc_sec;
  logic [63:0] dec_addr;
  logic [2:0]  acc_src, acc_func;
  logic [4:0]  acc_dev;
  logic [63:0] sz;
  int          error_cnt = 0;
  int          checks = 0;
  // reset values by index, unmapped ones read zero
  localparam logic [31:0] RV [11] = '{32'h1E, 32'hFE00_0009, 0, 0, 0, 32'hFC00_0000,
                                      32'hFFFF_FFFF, 0, 0, 0, 0};
  // hide table: register, value, device, function
  localparam logic [3:0]  HI [11] = '{9, 9, 9, 9, 9, 9, 9, 9, 10, 10, 10};
  localparam logic [31:0] HV [11] = '{32'h1, 32'h8, 32'h10, 32'h20, 32'h40, 32'h1000,
                                      32'h0400_0000, 32'h0800_0000, 32'h38, 32'h38, 32'h38};
  localparam logic [4:0]  HD [11] = '{0, 3, 4, 5, 6, 8, 16, 16, 8, 8, 8};
  localparam logic [2:0]  HF [11] = '{0, 0, 0, 0, 0, 3, 0, 1, 0, 1, 2};

  // 25 MHz clock
  always #20 core_clk_i = ~core_clk_i;

  mmd_decode dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .lane_strap_i(lane_strap_i),
    .trusted_lock_bit_i(trusted_lock_bit_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
    .cfg_idx_i(cfg_idx_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
    .cfg_ack_o(cfg_ack_o), .dec_valid_i(dec_valid), .dec_is64_i(dec_is64),
    .dec_addr_i(dec_addr), .dec_done_o(dec_done_o), .main_mem_o(main_mem_o),
    .prot_hit_o(prot_hit_o), .noncoh_o(noncoh_o), .acc_valid_i(acc_valid),
    .acc_src_i(acc_src), .acc_dev_i(acc_dev), .acc_func_i(acc_func),
    .acc_secondary_i(acc_sec), .acc_done_o(acc_done_o), .acc_abort_o(acc_abort_o));

  mmd_host_model host (.core_clk_i(core_clk_i), .dec_valid_o(dec_valid),
    .dec_is64_o(dec_is64), .dec_addr_o(dec_addr), .acc_valid_o(acc_valid),
    .acc_src_o(acc_src), .acc_dev_o(acc_dev), .acc_func_o(acc_func), .acc_sec_o(acc_sec));

  // compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // counts, verdict, end of run
  task automatic summarize();
    $display("checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // reset held six cycles
  task automatic do_reset();
    @(negedge core_clk_i);
    nrst_i = 1'b0;
    repeat (6) @(negedge core_clk_i);
    nrst_i = 1'b1;
  endtask
  // register write, answer one cycle later
  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    @(negedge core_clk_i);
    cfg_wr_i    = 1'b1;
    cfg_idx_i   = i;
    cfg_wdata_i = d;
    @(negedge core_clk_i);
    cfg_wr_i    = 1'b0;
    cfg_wdata_i = ~d;
    check(cfg_ack_o, 1);
  endtask
  // register read with expected value
  task automatic rd(input logic [3:0] i, input logic [31:0] e);
    @(negedge core_clk_i);
    cfg_rd_i  = 1'b1;
    cfg_idx_i = i;
    @(negedge core_clk_i);
    cfg_rd_i  = 1'b0;
    check({cfg_ack_o, cfg_rdata_o}, {1'b1, e});
  endtask
  // decode with expected main, protected, non-coherent flags
  task automatic dchk(input logic [63:0] a, input logic w, input logic [2:0] e);
    host.dec(a, w);
    check({dec_done_o, main_mem_o, prot_hit_o, noncoh_o}, {1'b1, e});
  endtask
  // config access with expected abort
  task automatic achk(input logic [2:0] s, input logic [4:0] d, input logic [2:0] f,
                      input logic sec, input logic e);
    host.acc(s, d, f, sec);
    check({acc_done_o, acc_abort_o}, {1'b1, e});
  endtask

  // watchdog
  initial begin
    repeat (20000) @(negedge core_clk_i);
    error_cnt++;
    summarize();
  end

  initial begin
    {nrst_i, cfg_wr_i, cfg_rd_i, trusted_lock_bit_i, cfg_idx_i, cfg_wdata_i} = '0;
    lane_strap_i = 3'h6;
    // one reset per trial, since the window takes only its first write
    for (int c = 0; c < 9; c++) begin
      do_reset();
      if (c == 0) begin
        // earliest request after release: range must still be empty
        dchk(64'hFFFF_FFFF_FFFF_FFFF, 1'b1, 3'b000);
        wr(`MMD_IDX_STRAP, 32'h0);
        for (int i = 0; i < 16; i++) rd(i, (i < 11) ? RV[i] : 32'h0);
        dchk(64'hFE7F_FFFF, 1'b0, 3'b010);
        dchk(64'hFE80_0000, 1'b0, 3'b000);
        dchk(64'h0, 1'b0, 3'b100);
      end
      sz = 64'h8_0000 << c[2:0];
      wr(`MMD_IDX_PWIN, {12'h100, 16'hFFFF, c[2:0], c < 8});
      wr(`MMD_IDX_PWIN, 32'h2000_0001);
      rd(`MMD_IDX_PWIN, {12'h100, 16'h0, c[2:0], c < 8});
      dchk(64'h1000_0000 + sz - 1, 1'b0, {1'b0, c < 5, 1'b0});
      dchk(64'h1000_0000 + sz, 1'b0, 3'b000);
    end
    wr(`MMD_IDX_LOTOP, 32'h0FFF_FFFF);
    rd(`MMD_IDX_LOTOP, 32'h0C00_0000);
    dchk(64'h0FFF_FFFF, 1'b0, 3'b100);
    dchk(64'h1000_0000, 1'b0, 3'b000);
    // high top written once only
    wr(`MMD_IDX_HITOP_L, 32'h07FF_FFFF);
    wr(`MMD_IDX_HITOP_H, 32'h1);
    rd(`MMD_IDX_HITOP_L, 32'h0400_0000);
    rd(`MMD_IDX_HITOP_H, 32'h0000_0001);
    dchk(64'h1_07FF_FFFF, 1'b1, 3'b100);
    dchk(64'h1_0800_0000, 1'b1, 3'b000);
    dchk(64'h0FFF_FFFF, 1'b1, 3'b000);
    // range kept inside the high region
    wr(`MMD_IDX_NCBASE_L, 32'h0);
    wr(`MMD_IDX_NCBASE_H, 32'h1);
    wr(`MMD_IDX_NCLIM_L, 32'h0400_0000);
    wr(`MMD_IDX_NCLIM_H, 32'h1);
    rd(`MMD_IDX_NCBASE_L, 32'h0000_0000);
    rd(`MMD_IDX_NCLIM_L, 32'h0400_0000);
    rd(`MMD_IDX_NCLIM_H, 32'h0000_0001);
    dchk(64'h1_0000_0000, 1'b1, 3'b101);
    dchk(64'h1_07FF_FFFF, 1'b1, 3'b101);
    dchk(64'h1_0800_0000, 1'b1, 3'b000);
    dchk(64'hFFFF_FFFF, 1'b0, 3'b000);
    for (int i = 0; i < 11; i++) begin
      // each entry's bit hides only host primary-side accesses to its device/function
      wr(HI[i], HV[i]);
      achk(MMD_SRC_HOST, HD[i], HF[i], 1'b0, 1'b1);
      achk(MMD_SRC_JTAG, HD[i], HF[i], 1'b0, 1'b0);
      achk(MMD_SRC_SMBUS, HD[i], HF[i], 1'b0, 1'b0);
      achk(MMD_SRC_HOST, HD[i], HF[i], 1'b1, 1'b0);
      achk(MMD_SRC_HOST, 5'h07, HF[i], 1'b0, 1'b0);
      wr(HI[i], 32'h0);
      achk(MMD_SRC_HOST, HD[i], HF[i], 1'b0, 1'b0);
    end
    trusted_lock_bit_i = 1'b1;
    wr(`MMD_IDX_HIDE1, 32'hFFFF_FFFF);
    rd(`MMD_IDX_HIDE1, 32'h0000_1079);
    achk(MMD_SRC_HOST, 5'h10, 3'h0, 1'b0, 1'b0);
    trusted_lock_bit_i = 1'b0;
    wr(`MMD_IDX_HIDE1, 32'hFFFF_FFFF);
    rd(`MMD_IDX_HIDE1, 32'h0C00_1079);
    wr(`MMD_IDX_HIDE2, 32'hFFFF_FFFF);
    rd(`MMD_IDX_HIDE2, 32'h0000_0038);
    summarize();
  end
endmodule
`default_nettype wire
